// >>> hbp_defines.svh
// Register offsets, field positions, reset values and constants of the HDLC byte engine
`ifndef HBP_DEFINES_SVH
`define HBP_DEFINES_SVH

// Register byte offsets
`define HBP_OFS_CTRL 8'h00
`define HBP_OFS_STATUS 8'h04
`define HBP_OFS_TXB 8'h08
`define HBP_OFS_TXO 8'h0C
`define HBP_OFS_RXI 8'h10
`define HBP_OFS_RXB 8'h14
`define HBP_OFS_TCRC 8'h18
`define HBP_OFS_RCRC 8'h1C
`define HBP_OFS_CLKSEL 8'h20
`define HBP_OFS_CMP0 8'h40
`define HBP_OFS_MSK0 8'h50

// Control register bits
`define HBP_CTL_TX_EN 0
`define HBP_CTL_RX_EN 1
`define HBP_CTL_POLY_LO 2
`define HBP_CTL_POLY_HI 3
`define HBP_CTL_INIT 4
`define HBP_CTL_TCRC_EN 5
`define HBP_CTL_RCRC_EN 6
`define HBP_CTL_AUTO_CLR 7
`define HBP_CTL_CMP_EN_LSB 8
`define HBP_CTL_IRQ_CAUSE 12

// Status register bits
`define HBP_ST_TX_IRQ 0
`define HBP_ST_RX_IRQ 1
`define HBP_ST_SC_IRQ 2
`define HBP_ST_TXO_FULL 3
`define HBP_ST_TX_PEND 4
`define HBP_ST_RX_PEND 5
`define HBP_ST_TX_BUSY 6
`define HBP_ST_RX_BUSY 7

// Processing clock select codes {bit1, bit0}
`define HBP_CLK_F1 2'b01
`define HBP_CLK_F8 2'b11
`define HBP_CLK_F2N 2'b10
`define HBP_F8_DIV 8'h08

// Check polynomial and presets
`define HBP_POLY_HDLC_SEL 2'b11
`define HBP_POLY_HDLC 16'h1021
`define HBP_CRC_PRESET_ONE 16'hFFFF
`define HBP_CRC_PRESET_ZERO 16'h0000
`define HBP_STUFF_RUN 3'h5
`define HBP_ONES_MAX 3'h7
`define HBP_BYTE_BITS 4'h8

`endif

// >>> hbp_pkg.sv
// Types shared by the HDLC byte engine
package hbp_pkg;

   typedef enum logic {HBP_IDLE, HBP_SHIFT} hbp_phase_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } hbp_bus_s;

   typedef struct packed {
      logic tx_irq_request;
      logic rx_irq_request;
      logic special_comm_irq_request;
   } hbp_irq_s;

   typedef struct packed {
      logic [12:0] ctrl;
      logic [1:0] clk_sel;
      logic [7:0] div_cnt;
      logic [7:0] tx_buffer_reg;
      logic tx_pending;
      hbp_phase_e tx_phase;
      logic [7:0] tx_shift;
      logic [3:0] tx_bits;
      logic [2:0] tx_ones;
      logic [7:0] tx_acc;
      logic [3:0] tx_acc_cnt;
      logic [7:0] tx_output_reg;
      logic tx_out_full;
      logic [15:0] tx_crc;
      logic [7:0] rx_input_reg;
      logic rx_pending;
      hbp_phase_e rx_phase;
      logic [7:0] rx_shift;
      logic [3:0] rx_bits;
      logic [2:0] rx_ones;
      logic [7:0] rx_acc;
      logic [3:0] rx_acc_cnt;
      logic [7:0] rx_buffer_reg;
      logic [15:0] rx_crc;
      logic [3:0][7:0] cmp;
      logic [3:0][7:0] msk;
      hbp_irq_s irq;
      logic [31:0] rdata;
   } hbp_state_s;

endpackage

// >>> hbp_engine.sv
// HDLC byte engine: bit stuffing, destuffing, pattern compare and running CRC
//
// Functional notes
// - Input and output are whole 8-bit words; input alignment is free.
// - Transmit byte is stuffed and delivered to the readable output register.
// - Receive input byte is destuffed and assembled into the receive buffer.
// - Receive input byte is also copied into the transmit buffer for comparing.
// - Transmit inserts a zero after five ones in a row.
// - Receive deletes the zero that follows five ones in a row.
// - Polynomial select 11 gives x16 + x12 + x5 + 1.
// - Initial-value bit one presets the check accumulator to FFFF.
// - Transmit check result readable when transmit check is enabled.
// - Transmit check result is reset while transmit enable is zero.
// - Receive check result readable when receive check is enabled.
// - With auto clear, a flag match on compare three resets receive check.
// - Transmit starts only with transmit enabled and buffer written.
// - Receive starts only with receive enabled and input written.
// - Cause zero: transmit request when buffer moves into shift register.
// - Cause one: transmit request when shift output reaches output register.
// - Transmit request also when received byte lands in the transmit buffer.
// - Receive request when an assembled byte reaches the receive buffer.
// - Receive request also when the input byte moves into the shift register.
// - Special request when received data matches any enabled compare register.
// - Check value updates once per converted data bit, both directions.
// - Transmit conversion stalls once a further byte is assembled while the output register holds unread data.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "hbp_defines.svh"

module hbp_engine #(
   parameter logic [7:0] F2N_DIV = 8'h02
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Request flags
   output logic tx_irq_request,
   output logic rx_irq_request,
   output logic special_comm_irq_request
);

   hbp_pkg::hbp_state_s state_reg;
   hbp_pkg::hbp_state_s state_next;
   hbp_pkg::hbp_bus_s bus;
   logic [3:0] match;

   // Bus signals gathered into one carrier
   assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // One MSB-first step of the check register; other selects hold the value
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic bit_in,
                                            input logic [1:0] sel);
      logic fb;
      fb = crc[15] ^ bit_in;
      if (sel == `HBP_POLY_HDLC_SEL)
      begin
         crc_step = {crc[14:0], 1'b0} ^ (fb ? `HBP_POLY_HDLC : 16'h0000);
      end
      else
      begin
         crc_step = crc;
      end
   endfunction

   // Masked compare of the received byte against each enabled pattern
   generate
      for (genvar j = 0; j < 4; j++)
      begin : g_cmp
         assign match[j] = state_reg.ctrl[`HBP_CTL_CMP_EN_LSB + j] &&
            (((state_reg.rx_input_reg ^ state_reg.cmp[j]) & ~state_reg.msk[j]) == 8'h00);
      end
   endgenerate

   // Next-state logic
   always_comb
   begin
      logic tick;
      logic tx_set;
      logic rx_set;
      logic sc_set;
      logic [2:0] clr;
      logic [1:0] sel;
      logic [15:0] preset;
      logic b;
      logic [3:0] idx;
      tick = 1'b0;
      tx_set = 1'b0;
      rx_set = 1'b0;
      sc_set = 1'b0;
      clr = 3'b000;
      b = 1'b0;
      idx = 4'h0;
      state_next = state_reg;
      sel = {state_reg.ctrl[`HBP_CTL_POLY_HI], state_reg.ctrl[`HBP_CTL_POLY_LO]};
      preset = state_reg.ctrl[`HBP_CTL_INIT] ? `HBP_CRC_PRESET_ONE
                                             : `HBP_CRC_PRESET_ZERO;
      state_next.rdata = 32'h0000_0000;

      // Processing rate; a stopped select freezes conversion but not the bus
      unique case (state_reg.clk_sel)
         `HBP_CLK_F1:
         begin
            tick = 1'b1;
         end
         `HBP_CLK_F8:
         begin
            tick = (state_reg.div_cnt == `HBP_F8_DIV - 8'h01);
         end
         `HBP_CLK_F2N:
         begin
            tick = (state_reg.div_cnt >= F2N_DIV - 8'h01);
         end
         default:
         begin
            tick = 1'b0;
         end
      endcase
      state_next.div_cnt = tick ? 8'h00 : state_reg.div_cnt + 8'h01;

      // Transmit: emit an assembled byte first, otherwise convert one bit
      if (state_reg.tx_acc_cnt == `HBP_BYTE_BITS)
      begin
         if (!state_reg.tx_out_full)
         begin
            state_next.tx_output_reg = state_reg.tx_acc;
            state_next.tx_out_full = 1'b1;
            state_next.tx_acc_cnt = 4'h0;
            tx_set = state_reg.ctrl[`HBP_CTL_IRQ_CAUSE];
         end
      end
      else if (tick && state_reg.tx_phase == hbp_pkg::HBP_SHIFT)
      begin
         state_next.tx_acc_cnt = state_reg.tx_acc_cnt + 4'h1;
         if (state_reg.tx_ones == `HBP_STUFF_RUN)
         begin
            // Stuffed zero is not data, so the check value does not see it
            state_next.tx_acc = {1'b0, state_reg.tx_acc[7:1]};
            state_next.tx_ones = 3'h0;
         end
         else
         begin
            b = state_reg.tx_shift[0];
            state_next.tx_acc = {b, state_reg.tx_acc[7:1]};
            state_next.tx_ones = b ? state_reg.tx_ones + 3'h1 : 3'h0;
            state_next.tx_shift = {1'b0, state_reg.tx_shift[7:1]};
            state_next.tx_bits = state_reg.tx_bits - 4'h1;
            if (state_reg.ctrl[`HBP_CTL_TCRC_EN])
            begin
               state_next.tx_crc = crc_step(state_reg.tx_crc, b, sel);
            end
            if (state_reg.tx_bits == 4'h1)
            begin
               state_next.tx_phase = hbp_pkg::HBP_IDLE;
            end
         end
      end

      // Transmit: move the buffer into the shift register
      if (state_reg.tx_pending && state_reg.tx_phase == hbp_pkg::HBP_IDLE)
      begin
         state_next.tx_shift = state_reg.tx_buffer_reg;
         state_next.tx_bits = `HBP_BYTE_BITS;
         state_next.tx_phase = hbp_pkg::HBP_SHIFT;
         state_next.tx_pending = 1'b0;
         tx_set = tx_set | !state_reg.ctrl[`HBP_CTL_IRQ_CAUSE];
      end

      // Receive: convert one bit, dropping the zero after five ones
      if (tick && state_reg.rx_phase == hbp_pkg::HBP_SHIFT)
      begin
         b = state_reg.rx_shift[0];
         state_next.rx_shift = {1'b0, state_reg.rx_shift[7:1]};
         state_next.rx_bits = state_reg.rx_bits - 4'h1;
         if (state_reg.rx_bits == 4'h1)
         begin
            state_next.rx_phase = hbp_pkg::HBP_IDLE;
         end
         if (state_reg.rx_ones == `HBP_STUFF_RUN && !b)
         begin
            state_next.rx_ones = 3'h0;
         end
         else
         begin
            // Runs past five ones are flags or aborts; count saturates
            state_next.rx_ones = !b ? 3'h0 : (state_reg.rx_ones == `HBP_ONES_MAX ?
               `HBP_ONES_MAX : state_reg.rx_ones + 3'h1);
            if (state_reg.ctrl[`HBP_CTL_RCRC_EN])
            begin
               state_next.rx_crc = crc_step(state_reg.rx_crc, b, sel);
            end
            if (state_reg.rx_acc_cnt == `HBP_BYTE_BITS - 4'h1)
            begin
               state_next.rx_buffer_reg = {b, state_reg.rx_acc[7:1]};
               state_next.rx_acc_cnt = 4'h0;
               rx_set = 1'b1;
            end
            else
            begin
               state_next.rx_acc = {b, state_reg.rx_acc[7:1]};
               state_next.rx_acc_cnt = state_reg.rx_acc_cnt + 4'h1;
            end
         end
      end

      // Receive: take the input byte, copy it for comparing, run the compare
      if (state_reg.rx_pending && state_reg.rx_phase == hbp_pkg::HBP_IDLE)
      begin
         state_next.rx_shift = state_reg.rx_input_reg;
         state_next.rx_bits = `HBP_BYTE_BITS;
         state_next.rx_phase = hbp_pkg::HBP_SHIFT;
         state_next.rx_pending = 1'b0;
         state_next.tx_buffer_reg = state_reg.rx_input_reg;
         tx_set = 1'b1;
         rx_set = 1'b1;
         sc_set = |match;
         if (match[3] && state_reg.ctrl[`HBP_CTL_AUTO_CLR])
         begin
            state_next.rx_crc = preset;
         end
      end

      // Register writes
      if (bus.wr)
      begin
         unique case (bus.addr)
            `HBP_OFS_CTRL:
            begin
               state_next.ctrl = bus.wdata[12:0];
            end
            `HBP_OFS_STATUS:
            begin
               clr = bus.wdata[2:0];
            end
            `HBP_OFS_TXB:
            begin
               if (state_reg.ctrl[`HBP_CTL_TX_EN])
               begin
                  state_next.tx_buffer_reg = bus.wdata[7:0];
                  state_next.tx_pending = 1'b1;
               end
            end
            `HBP_OFS_RXI:
            begin
               if (state_reg.ctrl[`HBP_CTL_RX_EN])
               begin
                  state_next.rx_input_reg = bus.wdata[7:0];
                  state_next.rx_pending = 1'b1;
               end
            end
            `HBP_OFS_RCRC:
            begin
               state_next.rx_crc = preset;
            end
            `HBP_OFS_CLKSEL:
            begin
               state_next.clk_sel = bus.wdata[1:0];
            end
            default:
            begin
               if (bus.addr[7:4] == `HBP_OFS_CMP0 >> 4)
               begin
                  state_next.cmp[bus.addr[3:2]] = bus.wdata[7:0];
               end
               else if (bus.addr[7:4] == `HBP_OFS_MSK0 >> 4)
               begin
                  state_next.msk[bus.addr[3:2]] = bus.wdata[7:0];
               end
            end
         endcase
      end

      // Transmit disable presets its check value and drops a pending byte
      if (!state_reg.ctrl[`HBP_CTL_TX_EN])
      begin
         state_next.tx_crc = preset;
         state_next.tx_pending = 1'b0;
      end

      // Register reads; data stands only in the following cycle
      if (bus.rd)
      begin
         idx = {2'b00, bus.addr[3:2]};
         unique case (bus.addr)
            `HBP_OFS_CTRL:
            begin
               state_next.rdata = {19'h0_0000, state_reg.ctrl};
            end
            `HBP_OFS_STATUS:
            begin
               state_next.rdata = {24'h00_0000,
                  state_reg.rx_phase == hbp_pkg::HBP_SHIFT,
                  state_reg.tx_phase == hbp_pkg::HBP_SHIFT,
                  state_reg.rx_pending, state_reg.tx_pending, state_reg.tx_out_full,
                  state_reg.irq.special_comm_irq_request,
                  state_reg.irq.rx_irq_request, state_reg.irq.tx_irq_request};
            end
            `HBP_OFS_TXB:
            begin
               state_next.rdata = {24'h00_0000, state_reg.tx_buffer_reg};
            end
            `HBP_OFS_TXO:
            begin
               state_next.rdata = {24'h00_0000, state_reg.tx_output_reg};
               // Reading frees the output register; a same-cycle refill wins
               if (state_reg.tx_acc_cnt != `HBP_BYTE_BITS || state_reg.tx_out_full)
               begin
                  state_next.tx_out_full = 1'b0;
               end
            end
            `HBP_OFS_RXI:
            begin
               state_next.rdata = {24'h00_0000, state_reg.rx_input_reg};
            end
            `HBP_OFS_RXB:
            begin
               state_next.rdata = {24'h00_0000, state_reg.rx_buffer_reg};
            end
            `HBP_OFS_TCRC:
            begin
               state_next.rdata = {16'h0000, state_reg.tx_crc};
            end
            `HBP_OFS_RCRC:
            begin
               state_next.rdata = {16'h0000, state_reg.rx_crc};
            end
            `HBP_OFS_CLKSEL:
            begin
               state_next.rdata = {30'h0000_0000, state_reg.clk_sel};
            end
            default:
            begin
               if (bus.addr[7:4] == `HBP_OFS_CMP0 >> 4)
               begin
                  state_next.rdata = {24'h00_0000, state_reg.cmp[idx[1:0]]};
               end
               else if (bus.addr[7:4] == `HBP_OFS_MSK0 >> 4)
               begin
                  state_next.rdata = {24'h00_0000, state_reg.msk[idx[1:0]]};
               end
            end
         endcase
      end

      // Sticky flags: write one clears, a same-cycle event wins
      state_next.irq.tx_irq_request =
         (state_reg.irq.tx_irq_request & ~clr[`HBP_ST_TX_IRQ]) | tx_set;
      state_next.irq.rx_irq_request =
         (state_reg.irq.rx_irq_request & ~clr[`HBP_ST_RX_IRQ]) | rx_set;
      state_next.irq.special_comm_irq_request =
         (state_reg.irq.special_comm_irq_request & ~clr[`HBP_ST_SC_IRQ]) | sc_set;
   end

   // State register
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state_reg <= '0;
         state_reg.tx_phase <= hbp_pkg::HBP_IDLE;
         state_reg.rx_phase <= hbp_pkg::HBP_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign rdata = state_reg.rdata;
   assign tx_irq_request = state_reg.irq.tx_irq_request;
   assign rx_irq_request = state_reg.irq.rx_irq_request;
   assign special_comm_irq_request = state_reg.irq.special_comm_irq_request;

endmodule // hbp_engine

// >>> hbp_engine_assertions.sv
// Port checker for the HDLC byte engine
`timescale 1ns/1ps
`include "hbp_defines.svh"

module hbp_engine_checker #(
   parameter logic [7:0] F2N_DIV = 8'h02
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // Request flags
   input wire logic tx_irq_request,
   input wire logic rx_irq_request,
   input wire logic special_comm_irq_request
);
   logic [12:0] ctrl_sh;
   logic [1:0] csel_sh;
   logic [1:0] ctrl_age;
   logic clr_wr;
   logic f1_tx;
   logic f1_rx;

   default clocking cb_chk @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // Decoded writes and f1 conditions
   assign clr_wr = wr && (addr == `HBP_OFS_STATUS);
   assign f1_tx = ctrl_sh[`HBP_CTL_TX_EN] && !ctrl_sh[`HBP_CTL_IRQ_CAUSE]
      && (csel_sh == `HBP_CLK_F1);
   assign f1_rx = ctrl_sh[`HBP_CTL_RX_EN] && (csel_sh == `HBP_CLK_F1);

   // Shadow of control; the age keeps the preset check off while a write settles
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         ctrl_sh <= 13'h0000;
         csel_sh <= 2'h0;
         ctrl_age <= 2'h3;
      end
      else
      begin
         if (wr && addr == `HBP_OFS_CTRL)
         begin
            ctrl_sh <= wdata[12:0];
            ctrl_age <= 2'h0;
         end
         else if (ctrl_age != 2'h3)
            ctrl_age <= ctrl_age + 2'h1;
         if (wr && addr == `HBP_OFS_CLKSEL)
            csel_sh <= wdata[1:0];
      end
   end

   a_tx_flag_holds: assert property (
      tx_irq_request && !(clr_wr && wdata[0]) |=> tx_irq_request)
      else $error("tx flag dropped");
   a_rx_flag_holds: assert property (
      rx_irq_request && !(clr_wr && wdata[1]) |=> rx_irq_request)
      else $error("rx flag dropped");
   a_sc_flag_holds: assert property (
      special_comm_irq_request && !(clr_wr && wdata[2]) |=> special_comm_irq_request)
      else $error("compare flag dropped");
   a_tx_load_flag: assert property (
      wr && addr == `HBP_OFS_TXB && f1_tx |-> ##[1:24] tx_irq_request)
      else $error("no tx flag after load");
   a_rx_input_flags: assert property (
      wr && addr == `HBP_OFS_RXI && f1_rx |-> ##[1:24] (rx_irq_request && tx_irq_request))
      else $error("no flags after rx input");
   a_tx_flag_enabled: assert property (
      $rose(tx_irq_request) |-> ctrl_sh[`HBP_CTL_TX_EN] || ctrl_sh[`HBP_CTL_RX_EN])
      else $error("tx flag while disabled");
   a_rx_flag_enabled: assert property (
      $rose(rx_irq_request) |-> ctrl_sh[`HBP_CTL_RX_EN])
      else $error("rx flag while disabled");
   a_tx_crc_preset: assert property (
      rd && addr == `HBP_OFS_TCRC && !ctrl_sh[`HBP_CTL_TX_EN] && ctrl_age == 2'h3
      |=> rdata == (ctrl_sh[`HBP_CTL_INIT] ? 32'h0000_FFFF : 32'h0000_0000))
      else $error("tx check not at preset");
endmodule // hbp_engine_checker

bind hbp_engine hbp_engine_checker #(.F2N_DIV(F2N_DIV)) chk_u (.clk(clk), .reset_n(reset_n),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .tx_irq_request(tx_irq_request), .rx_irq_request(rx_irq_request),
   .special_comm_irq_request(special_comm_irq_request));

// >>> hdlc_byte_processor_test.sv
// Self-checking testbench for the HDLC byte engine
`timescale 1ns/1ps
`include "hbp_defines.svh"

module hdlc_byte_processor_test;
   localparam logic [31:0] CFG = 32'h0000_09FF;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic tx_irq_request;
   logic rx_irq_request;
   logic special_comm_irq_request;
   int failures = 0;
   int total_checks = 0;
   int tbits = 0, tones = 0, rbits = 0, rones = 0;
   logic rd_seen = 1'b0;
   logic [31:0] exp_q[$];
   logic [7:0] adr_q[$];
   logic [7:0] txo_q[$];
   logic [7:0] rxb_q[$];
   logic [7:0] loop_q[$];
   logic [15:0] tcrc = 16'hFFFF;
   logic [15:0] rcrc = 16'hFFFF;
   logic [7:0] tacc = 8'h00;
   logic [7:0] racc = 8'h00;

   hbp_engine #(.F2N_DIV(8'h02)) dut_u (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_irq_request(tx_irq_request),
      .rx_irq_request(rx_irq_request), .special_comm_irq_request(special_comm_irq_request));

   // 25 MHz clock
   always #20 clk = ~clk;

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expd);
      total_checks++;
      if (seen !== expd)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, expd, seen);
      end
   endtask

   // Bus tasks leave strobes up; wait_idle drops them so no signal is set twice per step
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      adr_q.push_back(a);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask

   task automatic flags_are(input logic [2:0] e);
      check("flags", {29'h0000_0000, tx_irq_request, rx_irq_request,
         special_comm_irq_request}, {29'h0000_0000, e});
   endtask

   // Check polynomial x16 + x12 + x5 + 1, fed MSB end first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h1021 : 16'h0000);
   endfunction

   task automatic put_tx(input logic b);
      tacc[tbits] = b;
      tbits++;
      if (tbits == 8)
      begin
         txo_q.push_back(tacc);
         tbits = 0;
      end
   endtask

   // Transmit model: LSB first, stuffed bits kept out of the check; the engine
   // inserts a pending zero only when it shifts the next data bit, so a run that
   // ends a byte leaves its zero waiting for the following byte
   task automatic tx_model(input logic [7:0] d);
      for (int i = 0; i < 8; i++)
      begin
         if (tones == 5)
         begin
            put_tx(1'b0);
            tones = 0;
         end
         tcrc = crc_step(tcrc, d[i]);
         put_tx(d[i]);
         tones = d[i] ? tones + 1 : 0;
      end
   endtask

   // Receive model: a zero after five ones is dropped
   task automatic rx_model(input logic [7:0] d);
      for (int i = 0; i < 8; i++)
      begin
         if (rones == 5 && !d[i])
            rones = 0;
         else
         begin
            rcrc = crc_step(rcrc, d[i]);
            racc[rbits] = d[i];
            rbits++;
            rones = d[i] ? rones + 1 : 0;
            if (rbits == 8)
            begin
               rxb_q.push_back(racc);
               rbits = 0;
            end
         end
      end
   endtask

   // Reading the output register at once keeps conversion from stalling
   task automatic drain_tx();
      while (txo_q.size() > 0)
      begin
         loop_q.push_back(txo_q[0]);
         bus_rd(`HBP_OFS_TXO, {24'h00_0000, txo_q.pop_front()});
         wait_idle(14);
      end
   endtask

   task automatic give_verdict();
      $display("Checks made %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Read data is compared one cycle after its strobe
   always @(posedge clk)
   begin
      if (rd_seen)
         check($sformatf("rdata from %h", adr_q.pop_front()), rdata, exp_q.pop_front());
      rd_seen = rd;
   end

   // Watchdog, well beyond the fewer than one thousand cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      give_verdict();
   end

   initial
   begin
      logic [7:0] regs [7];
      logic [7:0] pat [4];
      logic [7:0] b;
      regs = '{`HBP_OFS_CTRL, `HBP_OFS_STATUS, `HBP_OFS_TXO, `HBP_OFS_RXB,
         `HBP_OFS_TCRC, `HBP_OFS_RCRC, 8'h30};
      pat = '{8'h7E, 8'hFF, 8'hFE, 8'h55};
      void'($urandom(32'hfe9b_af65));
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // Reset values, unmapped hole included
      bus_wr(8'h30, 32'hFFFF_FFFF);
      foreach (regs[i])
         bus_rd(regs[i], 32'h0000_0000);
      // f1 clock, abort and flag patterns, transmit held off first
      bus_wr(`HBP_OFS_CLKSEL, 32'h0000_0001);
      bus_wr(`HBP_OFS_CMP0, 32'h0000_00FE);
      bus_wr(`HBP_OFS_MSK0, 32'h0000_0001);
      bus_wr(`HBP_OFS_CMP0 + 8'h0C, 32'h0000_007E);
      bus_wr(`HBP_OFS_CTRL, CFG & 32'hFFFF_FFFE);
      wait_idle(4);
      bus_rd(`HBP_OFS_TCRC, 32'h0000_FFFF);
      bus_wr(`HBP_OFS_CTRL, CFG);
      bus_rd(`HBP_OFS_CTRL, CFG);
      // All-ones bytes force stuffing across a byte edge
      for (int n = 0; n < 6; n++)
      begin
         b = (n < 2) ? 8'hFF : 8'($urandom);
         bus_wr(`HBP_OFS_TXB, {24'h00_0000, b});
         tx_model(b);
         wait_idle(14);
         flags_are(3'b100);
         drain_tx();
      end
      bus_rd(`HBP_OFS_TCRC, {16'h0000, tcrc});
      // Completion cause: flag only once an output byte is complete
      bus_wr(`HBP_OFS_CTRL, CFG | 32'h0000_1000);
      for (int n = 0; n < 3; n++)
      begin
         b = 8'($urandom);
         bus_wr(`HBP_OFS_STATUS, 32'h0000_0007);
         bus_wr(`HBP_OFS_TXB, {24'h00_0000, b});
         tx_model(b);
         wait_idle(14);
         flags_are({txo_q.size() != 0, 2'b00});
         drain_tx();
      end
      // Transmit disabled: write refused, check back at preset
      bus_wr(`HBP_OFS_CTRL, CFG & 32'hFFFF_FFFE);
      bus_wr(`HBP_OFS_STATUS, 32'h0000_0007);
      bus_wr(`HBP_OFS_TXB, 32'h0000_00A5);
      wait_idle(14);
      flags_are(3'b000);
      bus_rd(`HBP_OFS_STATUS, 32'h0000_0000);
      bus_rd(`HBP_OFS_TCRC, 32'h0000_FFFF);
      // Stuffed stream looped back through the receiver
      bus_wr(`HBP_OFS_RCRC, 32'h0000_0000);
      bus_rd(`HBP_OFS_RCRC, 32'h0000_FFFF);
      foreach (loop_q[i])
      begin
         bus_wr(`HBP_OFS_RXI, {24'h00_0000, loop_q[i]});
         rx_model(loop_q[i]);
         wait_idle(14);
         flags_are(3'b110);
         bus_rd(`HBP_OFS_TXB, {24'h00_0000, loop_q[i]});
         while (rxb_q.size() > 0)
            bus_rd(`HBP_OFS_RXB, {24'h00_0000, rxb_q.pop_front()});
      end
      bus_rd(`HBP_OFS_RCRC, {16'h0000, rcrc});
      // Flag, abort under mask, plain match and a miss, at f1, f8 and the divided rate
      foreach (pat[i])
      begin
         bus_wr(`HBP_OFS_CLKSEL, {30'h0000_0000, (i == 1) ? `HBP_CLK_F8 :
            ((i == 3) ? `HBP_CLK_F2N : `HBP_CLK_F1)});
         bus_wr(`HBP_OFS_STATUS, 32'h0000_0007);
         bus_wr(`HBP_OFS_RXI, {24'h00_0000, pat[i]});
         // A flag match on compare three restarts the receive check
         if (pat[i] == 8'h7E)
            rcrc = `HBP_CRC_PRESET_ONE;
         rx_model(pat[i]);
         // Slow rates need eight divided ticks per byte
         wait_idle(80);
         flags_are({2'b11, pat[i] != 8'h55});
         while (rxb_q.size() > 0)
            bus_rd(`HBP_OFS_RXB, {24'h00_0000, rxb_q.pop_front()});
         bus_rd(`HBP_OFS_RCRC, {16'h0000, rcrc});
      end
      // Let the last read data be compared before the verdict
      wait_idle(2);
      give_verdict();
   end
endmodule // hdlc_byte_processor_test
